// *** sleep_exit_timer.sv ***
// Sleep-exit down timer: 32-bit loadable down counter with time-out flag.
// Assumes one bus clock clk_i, synchronous reset and a Wishbone master.
//
// Behaviour
// - Select bit picks 750 kHz internal (0) or 10 kHz low-power (1) tick.
// - Select bit is ignored while the external clock choice is set.
// - Control bit 3 set counts rising edges of the external timer clock pin.
// - Time-out sets flag bit 1; flag drives interrupt and wake request.
// - Writing 1 to the flag clears it; writing 0 leaves it.
// - Writing 1 to bit 2 clears and halts the counter; reads 0.
// - Count register write loads start value and begins counting down.
// - Count register read returns live counter, no tear protection.
// - Counts to zero, raises time-out, then stops until reloaded.
// - Only a non-zero count write starts a count-down.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
module sleep_exit_timer #(
	parameter int CLK_HZ  = wake_timer_pkg::BUS_CLK_HZ,
	parameter int FAST_HZ = wake_timer_pkg::FAST_HZ,
	parameter int SLOW_HZ = wake_timer_pkg::SLOW_HZ
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone slave
	input  wire wake_timer_pkg::wb_req_t wb_i,
	output logic [31:0]                  wb_dat_o,
	output logic                         wb_ack_o,
	// External counting clock pin
	input  wire logic                    external_timer_clock_pin_i,
	// Requests
	output logic                         irq_o,
	output logic                         wake_o
);
	import wake_timer_pkg::*;

	localparam int FAST_DIV = CLK_HZ / FAST_HZ;
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_DIV - 1);
	localparam logic [DIV_W-1:0] SLOW_LAST = DIV_W'(SLOW_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO  = '0;
	localparam logic [DIV_W-1:0] DIV_ONE   = DIV_W'(1);

	// Byte-lane merge of a write into an existing word
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	clk_cfg_t         cfg_q;
	logic             flag_q;
	logic             mask_q;
	logic [31:0]      count_q;
	logic [31:0]      count_d;
	tmr_state_t       state_q;
	tmr_state_t       state_d;
	logic [DIV_W-1:0] fast_cnt_q;
	logic [DIV_W-1:0] slow_cnt_q;
	logic             fast_tick_q;
	logic             slow_tick_q;
	logic [2:0]       pin_sync_q;
	logic             pin_lvl_q;
	logic             ext_tick_q;

	// Bus decode
	wire bus_req    = wb_i.cyc & wb_i.stb & ~wb_ack_o;
	wire bus_wr     = bus_req & wb_i.we;
	wire hit_ctrl   = wb_i.adr == CTRL_OFS;
	wire hit_mask   = wb_i.adr == MASK_OFS;
	wire hit_count  = wb_i.adr == COUNT_OFS;
	wire wr_ctrl0   = bus_wr & hit_ctrl & wb_i.sel[0];
	wire wr_mask0   = bus_wr & hit_mask & wb_i.sel[0];
	wire wr_count   = bus_wr & hit_count & (|wb_i.sel);
	wire [31:0] load_val = lane_merge(count_q, wb_i.dat, wb_i.sel);
	wire flag_w1c   = wr_ctrl0 & wb_i.dat[FLAG_BIT];
	wire ctr_clear  = wr_ctrl0 & wb_i.dat[CLEAR_BIT];

	// Counting tick selection
	wire int_tick   = cfg_q.clock_source_choice ? slow_tick_q
		: fast_tick_q;
	wire cnt_tick   = cfg_q.external_clock_choice ? ext_tick_q
		: int_tick;
	wire running    = state_q == ST_RUN;
	wire count_last = count_q == ONE_WORD;
	wire last_tick  = running & cnt_tick & count_last;
	wire timeout    = last_tick & ~wr_count & ~ctr_clear;

	// Read mux; counter-clear bit always reads 0
	wire [31:0] ctrl_rd = {28'h000_0000, cfg_q.external_clock_choice,
		1'b0, flag_q, cfg_q.clock_source_choice};
	wire [31:0] mask_rd = {30'h0000_0000, mask_q, 1'b0};
	wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd
		: hit_mask ? mask_rd
		: hit_count ? count_q
		: ZERO_WORD;

	// Counter next state
	always_comb begin
		count_d = count_q;
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (wr_count) begin
					count_d = load_val;
					state_d = (load_val != ZERO_WORD) ? ST_RUN
						: ST_IDLE;
				end
			end
			ST_RUN: begin
				if (wr_count) begin
					count_d = load_val;
					state_d = (load_val != ZERO_WORD) ? ST_RUN : ST_IDLE;
				end else if (cnt_tick) begin
					count_d = count_q - ONE_WORD;
					if (count_q == ONE_WORD) begin
						state_d = ST_IDLE;
					end
				end
			end
		endcase
		if (ctr_clear) begin
			count_d = ZERO_WORD;
			state_d = ST_IDLE;
		end
	end

	// Present count, read back live with no tear guard
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= COUNT_RST;
		end else begin
			count_q <= count_d;
		end
	end

	// Run state: left only by time-out, clear or a zero load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Divider step shared by both internal rates
	function automatic logic [DIV_W-1:0] div_step(
		input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] lim);
		return (cnt == lim) ? DIV_ZERO : cnt + DIV_ONE;
	endfunction : div_step

	// Divider next values and wrap strobes
	wire [DIV_W-1:0] fast_cnt_d = div_step(fast_cnt_q, FAST_LAST);
	wire [DIV_W-1:0] slow_cnt_d = div_step(slow_cnt_q, SLOW_LAST);
	wire             fast_wrap  = fast_cnt_q == FAST_LAST;
	wire             slow_wrap  = slow_cnt_q == SLOW_LAST;

	// Fast divider: one-cycle enable at the internal oscillator rate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_cnt_q  <= DIV_ZERO;
			fast_tick_q <= 1'b0;
		end else begin
			fast_cnt_q  <= fast_cnt_d;
			fast_tick_q <= fast_wrap;
		end
	end

	// Slow divider: stands in for the low-power oscillator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_cnt_q  <= DIV_ZERO;
			slow_tick_q <= 1'b0;
		end else begin
			slow_cnt_q  <= slow_cnt_d;
			slow_tick_q <= slow_wrap;
		end
	end

	// External pin: a level counts once stages two and three agree
	wire pin_agree = pin_sync_q[1] == pin_sync_q[2];
	wire pin_lvl_d = pin_agree ? pin_sync_q[2] : pin_lvl_q;
	wire pin_rise  = pin_agree & pin_sync_q[2] & ~pin_lvl_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync_q <= 3'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], external_timer_clock_pin_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_lvl_q <= 1'b0;
		end else begin
			pin_lvl_q <= pin_lvl_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_tick_q <= 1'b0;
		end else begin
			ext_tick_q <= pin_rise;
		end
	end

	// Next values of control, flag and mask; a time-out beats a clear
	wire      wr_ext_sel = wb_i.dat[EXTSEL_BIT];
	wire      wr_src_sel = wb_i.dat[SRC_SEL_BIT];
	clk_cfg_t cfg_wr;
	clk_cfg_t cfg_d;
	logic     flag_d;
	logic     mask_d;
	assign cfg_wr = '{external_clock_choice: wr_ext_sel,
		clock_source_choice: wr_src_sel};
	assign cfg_d  = wr_ctrl0 ? cfg_wr : cfg_q;
	assign flag_d = timeout | (flag_q & ~flag_w1c);
	assign mask_d = wr_mask0 ? wb_i.dat[FLAG_BIT] : mask_q;

	// Clock choice, taken from byte lane zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= '{external_clock_choice: EXTSEL_RST,
				clock_source_choice: SRC_SEL_RST};
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Sticky time-out flag, cleared by writing one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// Interrupt mask, same layout as the control flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	// Bus answer: one ack per request, data only beside the ack
	logic        ack_d;
	logic [31:0] dat_d;
	logic        irq_d;
	logic        wake_d;
	assign ack_d  = bus_req;
	assign dat_d  = bus_req ? rd_mux : ZERO_WORD;
	assign irq_d  = flag_q & mask_q;
	assign wake_d = flag_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= ack_d;
		end
	end

	// Read data, zero outside the ack cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= ZERO_WORD;
		end else begin
			wb_dat_o <= dat_d;
		end
	end

	// Requests: irq honours the mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_d;
		end
	end

	// Wake request ignores the mask so sleep can always end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_o <= 1'b0;
		end else begin
			wake_o <= wake_d;
		end
	end

endmodule : sleep_exit_timer

// *** sleep_exit_timer_monitor.sv ***
// Concurrent checks on the sleep-exit timer's ports.
// Assumes a master that holds each request until it sees ack.
`timescale 1ns/100ps
module timer_monitor
	import wake_timer_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Watched ports
	input wire wb_req_t     wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        external_timer_clock_pin_i,
	input wire logic        irq_o,
	input wire logic        wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_i.cyc && wb_i.stb && !wb_ack_o;
	wire ctl = wb_ack_o && wb_i.adr == CTRL_OFS;
	wire w1c = ctl && wb_i.we && wb_i.sel[0] && wb_i.dat[1];
	ack_once_a: // Ack is a single-cycle pulse
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_due_a: // Each request is answered one cycle later
		assert property (req |=> wb_ack_o) else $error("ack missing");
	dat_idle_a:
		assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
	ctl_read_a:
		assert property (ctl && !wb_i.we |-> wb_dat_o[31:4] == 28'h0
			&& !wb_dat_o[2]) else $error("clear bit read back");
	hole_read_a: // Unmapped offset 8 reads as zero
		assert property (wb_ack_o && wb_i.adr == 4'h8 |-> wb_dat_o == 32'h0)
			else $error("unmapped read");
	irq_wake_a:
		assert property (irq_o |-> wake_o) else $error("irq without flag");
	clr_wake_a:
		assert property (w1c |-> ##2 !wake_o) else $error("flag kept");
	wake_fall_a:
		assert property ($fell(wake_o) |-> $past(w1c))
			else $error("flag lost");
	cover property (w1c && wake_o);
	cover property ($rose(irq_o));
	cover property (wake_o && !irq_o);
endmodule : timer_monitor

bind sleep_exit_timer timer_monitor u_timer_monitor (.clk_i(clk_i),
	.rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.external_timer_clock_pin_i(external_timer_clock_pin_i),
	.irq_o(irq_o), .wake_o(wake_o));

// *** test_sleep_exit_timer.sv ***
// Self-checking bench of the sleep-exit timer.
// Assumes the package and the monitor are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %s exp %0h got %0h", nm, e, g); end end
module test_sleep_exit_timer;
	import wake_timer_pkg::*;
	logic        clk_i = 0, rst_i = 1, pin = 0, wb_ack_o, irq_o, wake_o;
	wb_req_t     wb_i = '0;
	logic [31:0] wb_dat_o, r, v;
	logic [3:0]  md[4] = '{4'h0, 4'h1, 4'h8, 4'h9};
	int          error_cnt, n_checks, cyc, n, len, seed = 25;
	sleep_exit_timer #(.FAST_HZ(5_000_000), .SLOW_HZ(1_000_000))
		u_sleep_exit_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.external_timer_clock_pin_i(pin), .wake_o(wake_o));
	initial forever #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc % 6 == 0) pin <= ~pin;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// Tick period in bus clocks for a control setting
	function int per(logic [3:0] m);
		return m[3] ? 12 : (m[0] ? 25 : 5);
	endfunction : per
	task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
		wb_i <= '{1'b1, 1'b1, w, a, 4'hF, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		r = wb_dat_o;
		wb_i <= '0;
		@(posedge clk_i);
	endtask : wb
	task automatic wait_wake(int lim);
		n = 0;
		while (wake_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_wake
	task report_and_stop;
		$display("Checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(0, CTRL_OFS, 0);
		`CHK("ctrl", 32'h0, r)
		wb(0, MASK_OFS, 0);
		`CHK("mask", 32'h2, r)
		wb(0, 4'h8, 0);
		`CHK("hole", 32'h0, r)
		$display("Test reset done");
		foreach (md[i]) begin
			len = 3 + $unsigned($random(seed)) % 6;
			wb(1, CTRL_OFS, {28'h0, md[i]});
			wb(1, COUNT_OFS, len);
			wb(0, COUNT_OFS, 0);
			`CHK("live", 1'b1, r inside {[1:len]})
			wait_wake(per(md[i]) * (len + 1) + 8);
			`CHK("wake", 1'b1, wake_o)
			`CHK("irq", 1'b1, irq_o)
			`CHK("period", 1'b1, n + 4 >= per(md[i]) * (len - 1))
			wb(0, COUNT_OFS, 0);
			`CHK("stopped", 32'h0, r)
			wb(1, CTRL_OFS, {28'h0, md[i]});
			wb(0, CTRL_OFS, 0);
			`CHK("keep", {28'h0, md[i] | 4'h2}, r)
			wb(1, CTRL_OFS, {28'h0, md[i] | 4'h2});
			@(posedge clk_i);
			`CHK("clear", 2'b00, {wake_o, irq_o})
			$display("Test mode %0h done", md[i]);
		end
		v = $random(seed) | 32'h0010_0000;
		wb(1, COUNT_OFS, v);
		wb(0, COUNT_OFS, 0);
		`CHK("load", 1'b1, r inside {[v - 2:v]})
		wb(0, COUNT_OFS, 0);
		`CHK("reread", 1'b1, r inside {[v - 2:v]})
		wb(1, CTRL_OFS, 32'h4);
		wb(0, COUNT_OFS, 0);
		`CHK("cleared", 32'h0, r)
		wb(1, COUNT_OFS, 0);
		wait_wake(400);
		`CHK("halt", 1'b0, wake_o)
		$display("Test clear done");
		wb(1, MASK_OFS, 0);
		wb(1, COUNT_OFS, 1);
		wait_wake(30);
		`CHK("masked", 2'b10, {wake_o, irq_o})
		wb(1, CTRL_OFS, 32'h2);
		$display("Test mask done");
		report_and_stop();
	end
endmodule : test_sleep_exit_timer

// *** wake_timer_pkg.sv ***
// Constants, register map and carrier types of the sleep-exit down timer.
// Assumes a 25 MHz bus clock and a classic Wishbone register port.
package wake_timer_pkg;

	// Register byte offsets
	localparam logic [3:0] CTRL_OFS  = 4'h0;
	localparam logic [3:0] MASK_OFS  = 4'h4;
	localparam logic [3:0] COUNT_OFS = 4'hC;

	// Field positions in timer_control and irq_mask
	localparam int SRC_SEL_BIT = 0;
	localparam int FLAG_BIT   = 1;
	localparam int CLEAR_BIT  = 2;
	localparam int EXTSEL_BIT = 3;

	// Reset values and word constants
	localparam logic        SRC_SEL_RST = 1'b0;
	localparam logic        EXTSEL_RST = 1'b0;
	localparam logic        MASK_RST   = 1'b1;
	localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
	localparam logic [31:0] ONE_WORD   = 32'h0000_0001;

	// Clock rates in Hz and divider width
	localparam int BUS_CLK_HZ = 25_000_000;
	localparam int FAST_HZ    = 750_000;
	localparam int SLOW_HZ    = 10_000;
	localparam int DIV_W      = 12;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	// Software-written clock choice
	typedef struct packed {
		logic external_clock_choice;
		logic clock_source_choice;
	} clk_cfg_t;

	// Counter state, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} tmr_state_t;

endpackage : wake_timer_pkg
